// >>> design/ccrm_register_bank.sv
/*
 Holding-register bank of the counter unit: link register access, range checks and settings.
 Assumes requests arrive as single-register pulses from a frame engine on the same clock.
*/
`timescale 1ns/10ps
// Functional notes
// - Read-only task register shows relays one to four activation state in low bits.
// - Policy 0 applies settings at once; 1 waits for counter clear or power-up.
// - Auxiliary input mode 0 to 2: unused, direction select, counter freeze.
// - Clear sources 0 to 3: all, terminal plus link, button plus link, link only.
// - Autoreset 0 off, 1 at relay one threshold, 2 below zero.
// - Filter code 0 to 9: 10kHz, otherwise ten hertz times code.
// - Mode 0 adds A and B pulses; mode 1 adds A, subtracts B.
// - Mode 2 counts per quadrature cycle; mode 3 per quarter cycle.
// - Signed multiplier in two words, range -99999 to 999999.
// - Divider in two words, range 1 to 999999.
// - Signed offset in two words, range -99999 to 999999.
// - Decimal place setting 0 to 5.
// - Fixed read-only identification code.
// - Line rate code 0 to 7, from 1200 to 115200 baud.
// - Link writes accepted only while write permission is 1.
// - Five lock flags in bits 0 to 4.
// - Reply delay code 0 to 5.
// - Frame gap limit 0 disables, 1 to 99 seconds.
// - Display level 1 to 8.
// - Entry style bit: digit edit or ramp entry.
// - Signed relay one threshold in two words, range -99999 to 999999.
// - Relay one behaviour code 0 to 3.
// - Words are two's complement; wide values are high word then low word.
// - Reply to station address write carries the old address.
// - Link may clear write permission but never set it; panel re-enables.
// - Write refused for missing permission answers exception 08h.
module ccrm_register_bank
   import ccrm_pkg::*;
#(
   parameter logic [15:0] unit_identity_code = 16'h5a5a // Arbitrary value.
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // Register requests from the link frame engine.
   input wire logic req_valid,
   input wire ccrm_request_type req,
   // Answers to the frame engine.
   output ccrm_answer_type ans,
   output logic ans_valid,
   // Counter core and front panel.
   input wire logic [3:0] relay_task_in,
   input wire logic counter_cleared,
   input wire logic panel_permit_set,
   // Settings in use and live link parameters.
   output ccrm_settings_type settings,
   output logic [7:0] station_now,
   output logic link_write_permit
);

   logic [15:0] bank [0:ccrm_bank_depth-1];
   logic [15:0] next_bank [0:ccrm_bank_depth-1];
   logic [3:0] relay_task;
   ccrm_answer_type next_ans;
   logic next_ans_valid;
   ccrm_settings_type next_settings;
   ccrm_settings_type live;

   function automatic logic [15:0] reset_word(input logic [5:0] a);
      logic [15:0] v;
      v = ccrm_reset_zero;
      if (a == ccrm_prescale_count_low)
         v = ccrm_reset_div_low;
      if (a == ccrm_scale_factor_low)
         v = ccrm_reset_mul_low;
      if (a == ccrm_station_address)
         v = ccrm_reset_station;
      if (a == ccrm_line_rate_select)
         v = ccrm_reset_line_rate;
      if (a == ccrm_link_write_permit)
         v = ccrm_reset_permit;
      if (a == ccrm_display_level)
         v = ccrm_reset_level;
      return v;
   endfunction : reset_word

   // Upper limit of a plain setting; zero marks an address that is not a plain setting.
   function automatic logic [15:0] plain_max(input logic [5:0] a);
      logic [15:0] m;
      m = 16'h0000;
      unique case (a)
         ccrm_param_apply_policy: m = ccrm_max_policy;
         ccrm_aux_input_mode: m = ccrm_max_aux;
         ccrm_clear_source_select: m = ccrm_max_clear_src;
         ccrm_auto_clear_select: m = ccrm_max_auto_clear;
         ccrm_input_filter_rate: m = ccrm_max_filter;
         ccrm_count_operation_mode: m = ccrm_max_count_mode;
         ccrm_decimal_place_setting: m = ccrm_max_point;
         ccrm_station_address: m = ccrm_max_station;
         ccrm_line_rate_select: m = ccrm_max_line_rate;
         ccrm_lock_flags: m = ccrm_max_lock;
         ccrm_reply_delay_select: m = ccrm_max_reply_delay;
         ccrm_frame_gap_limit: m = ccrm_max_gap;
         ccrm_display_level: m = ccrm_max_level;
         ccrm_entry_style: m = ccrm_max_entry;
         ccrm_relay_one_behaviour: m = ccrm_max_relay_mode;
         default: m = 16'h0000;
      endcase
      return m;
   endfunction : plain_max

   function automatic logic is_pair(input logic [5:0] a);
      return a == ccrm_scale_factor_high || a == ccrm_scale_factor_low
         || a == ccrm_prescale_count_high || a == ccrm_prescale_count_low
         || a == ccrm_zero_shift_high || a == ccrm_zero_shift_low
         || a == ccrm_relay_one_threshold_high || a == ccrm_relay_one_threshold_low;
   endfunction : is_pair

   // Register access and range checks.
   always_comb
   begin
      logic [5:0] a;
      logic [5:0] hi;
      logic [5:0] lo;
      logic mapped;
      logic signed [31:0] lower;
      logic signed [31:0] cand;
      logic signed [31:0] clamped;
      a = req.address[5:0];
      hi = {a[5:1], 1'b0};
      lo = {a[5:1], 1'b1};
      mapped = req.address[15:6] == 10'h000;
      lower = (hi == ccrm_prescale_count_high) ? ccrm_div_min : ccrm_wide_min;
      cand = 32'sd0;
      clamped = 32'sd0;
      next_bank = bank;
      next_ans_valid = req_valid;
      next_ans.data = 16'h0000;
      next_ans.exception = ccrm_exc_none;
      next_ans.reply_station = bank[ccrm_station_address][7:0];
      if (req_valid && !req.write)
      begin
         if (!mapped)
            next_ans.exception = ccrm_exc_address;
         else if (a == ccrm_relay_task_state)
            next_ans.data = {12'h000, relay_task};
         else if (a == ccrm_unit_identity)
            next_ans.data = unit_identity_code;
         else if (plain_max(a) != 16'h0000 || a == ccrm_link_write_permit || is_pair(a))
            next_ans.data = bank[a];
         else
            next_ans.exception = ccrm_exc_address;
      end
      else if (req_valid)
      begin
         // Permission is checked first, so a locked unit answers every write the same way.
         if (bank[ccrm_link_write_permit] == 16'h0000)
            next_ans.exception = ccrm_exc_permit;
         else if (!mapped)
            next_ans.exception = ccrm_exc_address;
         else if (a == ccrm_relay_task_state || a == ccrm_unit_identity)
            next_ans.exception = ccrm_exc_address;
         else if (a == ccrm_link_write_permit)
         begin
            if (req.data > ccrm_max_permit)
               next_ans.exception = ccrm_exc_value;
            else if (req.data == 16'h0000)
               next_bank[a] = 16'h0000;
         end
         else if (is_pair(a))
         begin
            if (a == hi)
            begin
               // A high word write may pull the low word into range rather than fail.
               cand = $signed({req.data, bank[lo]});
               clamped = (cand < lower) ? lower : ((cand > ccrm_wide_max) ? ccrm_wide_max : cand);
               if (clamped[31:16] != req.data)
                  next_ans.exception = ccrm_exc_value;
               else
               begin
                  next_bank[hi] = req.data;
                  next_bank[lo] = clamped[15:0];
               end
            end
            else
            begin
               cand = $signed({bank[hi], req.data});
               if (cand < lower || cand > ccrm_wide_max)
                  next_ans.exception = ccrm_exc_value;
               else
                  next_bank[lo] = req.data;
            end
         end
         else if (plain_max(a) == 16'h0000)
            next_ans.exception = ccrm_exc_address;
         else if (req.data > plain_max(a) || (a == ccrm_display_level && req.data < ccrm_min_level))
            next_ans.exception = ccrm_exc_value;
         else
         begin
            next_ans.data = req.data;
            next_bank[a] = req.data;
         end
      end
      if (req_valid && req.write && next_ans.exception == ccrm_exc_none)
         next_ans.data = req.data;
      // The panel set wins over a link clear in the same cycle, so the menu can always restore writes.
      if (panel_permit_set)
         next_bank[ccrm_link_write_permit] = ccrm_reset_permit;
   end

   // Settings built from the live bank.
   always_comb
   begin
      live.aux_input_mode = bank[ccrm_aux_input_mode][1:0];
      live.clear_source_select = bank[ccrm_clear_source_select][1:0];
      live.auto_clear_select = bank[ccrm_auto_clear_select][1:0];
      live.input_filter_rate = bank[ccrm_input_filter_rate][3:0];
      live.count_operation_mode = bank[ccrm_count_operation_mode][1:0];
      live.scale_factor = {bank[ccrm_scale_factor_high], bank[ccrm_scale_factor_low]};
      live.prescale_count = {bank[ccrm_prescale_count_high], bank[ccrm_prescale_count_low]};
      live.zero_shift = {bank[ccrm_zero_shift_high], bank[ccrm_zero_shift_low]};
      live.decimal_place_setting = bank[ccrm_decimal_place_setting][2:0];
      live.line_rate_select = bank[ccrm_line_rate_select][2:0];
      live.lock_flags = bank[ccrm_lock_flags][4:0];
      live.reply_delay_select = bank[ccrm_reply_delay_select][2:0];
      live.frame_gap_limit = bank[ccrm_frame_gap_limit][6:0];
      live.display_level = bank[ccrm_display_level][3:0];
      live.entry_style = bank[ccrm_entry_style][0];
      live.relay_one_threshold = {bank[ccrm_relay_one_threshold_high], bank[ccrm_relay_one_threshold_low]};
      live.relay_one_behaviour = bank[ccrm_relay_one_behaviour][1:0];
      // Deferred settings keep the counter consistent until the next clear.
      if (bank[ccrm_param_apply_policy][0] == 1'b0 || counter_cleared)
         next_settings = live;
      else
         next_settings = settings;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < ccrm_bank_depth; i++)
            bank[i] <= reset_word(6'(i));
         relay_task <= 4'h0;
         ans <= '0;
         ans_valid <= 1'b0;
         settings <= '0;
         station_now <= 8'h00;
         link_write_permit <= 1'b0;
      end
      else
      begin
         bank <= next_bank;
         relay_task <= relay_task_in;
         ans <= next_ans;
         ans_valid <= next_ans_valid;
         settings <= next_settings;
         station_now <= bank[ccrm_station_address][7:0];
         link_write_permit <= bank[ccrm_link_write_permit][0];
      end
   end

endmodule : ccrm_register_bank

// >>> design/ccrm_pkg.sv
/*
 Shared constants and types for the counter configuration register bank.
 Assumes a frame engine elsewhere decodes link frames into single register requests.
*/
package ccrm_pkg;
   localparam int ccrm_addr_width = 6;
   localparam int ccrm_bank_depth = 64;
   // Register offsets.
   localparam logic [5:0] ccrm_relay_task_state = 6'h09;
   localparam logic [5:0] ccrm_param_apply_policy = 6'h10;
   localparam logic [5:0] ccrm_aux_input_mode = 6'h11;
   localparam logic [5:0] ccrm_clear_source_select = 6'h12;
   localparam logic [5:0] ccrm_auto_clear_select = 6'h13;
   localparam logic [5:0] ccrm_input_filter_rate = 6'h14;
   localparam logic [5:0] ccrm_count_operation_mode = 6'h15;
   localparam logic [5:0] ccrm_scale_factor_high = 6'h16;
   localparam logic [5:0] ccrm_scale_factor_low = 6'h17;
   localparam logic [5:0] ccrm_prescale_count_high = 6'h18;
   localparam logic [5:0] ccrm_prescale_count_low = 6'h19;
   localparam logic [5:0] ccrm_zero_shift_high = 6'h1a;
   localparam logic [5:0] ccrm_zero_shift_low = 6'h1b;
   localparam logic [5:0] ccrm_decimal_place_setting = 6'h1c;
   localparam logic [5:0] ccrm_station_address = 6'h20;
   localparam logic [5:0] ccrm_unit_identity = 6'h21;
   localparam logic [5:0] ccrm_line_rate_select = 6'h22;
   localparam logic [5:0] ccrm_link_write_permit = 6'h23;
   localparam logic [5:0] ccrm_lock_flags = 6'h24;
   localparam logic [5:0] ccrm_reply_delay_select = 6'h25;
   localparam logic [5:0] ccrm_frame_gap_limit = 6'h27;
   localparam logic [5:0] ccrm_display_level = 6'h2d;
   localparam logic [5:0] ccrm_entry_style = 6'h2f;
   localparam logic [5:0] ccrm_relay_one_threshold_high = 6'h30;
   localparam logic [5:0] ccrm_relay_one_threshold_low = 6'h31;
   localparam logic [5:0] ccrm_relay_one_behaviour = 6'h32;
   // Ranges of plain settings.
   localparam logic [15:0] ccrm_max_policy = 16'h0001;
   localparam logic [15:0] ccrm_max_aux = 16'h0002;
   localparam logic [15:0] ccrm_max_clear_src = 16'h0003;
   localparam logic [15:0] ccrm_max_auto_clear = 16'h0002;
   localparam logic [15:0] ccrm_max_filter = 16'h0009;
   localparam logic [15:0] ccrm_max_count_mode = 16'h0003;
   localparam logic [15:0] ccrm_max_point = 16'h0005;
   localparam logic [15:0] ccrm_max_station = 16'h00c7;
   localparam logic [15:0] ccrm_max_line_rate = 16'h0007;
   localparam logic [15:0] ccrm_max_permit = 16'h0001;
   localparam logic [15:0] ccrm_max_lock = 16'h001f;
   localparam logic [15:0] ccrm_max_reply_delay = 16'h0005;
   localparam logic [15:0] ccrm_max_gap = 16'h0063;
   localparam logic [15:0] ccrm_min_level = 16'h0001;
   localparam logic [15:0] ccrm_max_level = 16'h0008;
   localparam logic [15:0] ccrm_max_entry = 16'h0001;
   localparam logic [15:0] ccrm_max_relay_mode = 16'h0003;
   // Ranges of split 32-bit values.
   localparam logic signed [31:0] ccrm_wide_min = -32'sd99999;
   localparam logic signed [31:0] ccrm_wide_max = 32'sd999999;
   localparam logic signed [31:0] ccrm_div_min = 32'sd1;
   // Values after reset.
   localparam logic [15:0] ccrm_reset_zero = 16'h0000;
   localparam logic [15:0] ccrm_reset_div_low = 16'h0001;
   localparam logic [15:0] ccrm_reset_mul_low = 16'h0001;
   localparam logic [15:0] ccrm_reset_station = 16'h0001;
   localparam logic [15:0] ccrm_reset_line_rate = 16'h0003;
   localparam logic [15:0] ccrm_reset_permit = 16'h0001;
   localparam logic [15:0] ccrm_reset_level = 16'h0008;
   // Exception codes.
   localparam logic [7:0] ccrm_exc_none = 8'h00;
   localparam logic [7:0] ccrm_exc_address = 8'h02;
   localparam logic [7:0] ccrm_exc_value = 8'h03;
   localparam logic [7:0] ccrm_exc_permit = 8'h08;

   typedef struct packed {
      logic write;
      logic [15:0] address;
      logic [15:0] data;
   } ccrm_request_type;

   typedef struct packed {
      logic [15:0] data;
      logic [7:0] exception;
      logic [7:0] reply_station;
   } ccrm_answer_type;

   typedef struct packed {
      logic [1:0] aux_input_mode;
      logic [1:0] clear_source_select;
      logic [1:0] auto_clear_select;
      logic [3:0] input_filter_rate;
      logic [1:0] count_operation_mode;
      logic [31:0] scale_factor;
      logic [31:0] prescale_count;
      logic [31:0] zero_shift;
      logic [2:0] decimal_place_setting;
      logic [2:0] line_rate_select;
      logic [4:0] lock_flags;
      logic [2:0] reply_delay_select;
      logic [6:0] frame_gap_limit;
      logic [3:0] display_level;
      logic entry_style;
      logic [31:0] relay_one_threshold;
      logic [1:0] relay_one_behaviour;
   } ccrm_settings_type;
endpackage : ccrm_pkg

// >>> tb/ccrm_master_model.sv
/*
 Behavioural link master that hands single register requests to the bank.
 Assumes the bench calls send and that the bank takes a request at the rising edge.
*/
`timescale 1ns/10ps
module ccrm_master_model
   import ccrm_pkg::*;
(
   // Clock.
   input wire logic clock,
   // Requests to the bank.
   output logic req_valid,
   output ccrm_request_type req
);
   initial
   begin
      req_valid = 1'b0;
      req = '0;
   end

   // Callers put the high word of a split value before its low word.
   task automatic send(input logic w, input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      #1;
      req_valid = 1'b1;
      req = '{write: w, address: a, data: d};
      @(posedge clock);
      #1;
      req_valid = 1'b0;
      // Released lines show the inverse, so a stale request cannot pass for a held one.
      req = ~req;
   endtask : send
endmodule : ccrm_master_model

// >>> tb/ccrm_register_bank_checker.sv
/*
 Concurrent checks on the ports of the counter register bank.
 Assumes one clock domain and the synchronous active-low reset of the bank.
*/
`timescale 1ns/10ps
module ccrm_register_bank_checker
   import ccrm_pkg::*;
#(
   parameter logic [15:0] unit_identity_code = 16'h5a5a // Arbitrary value.
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // Request and answer.
   input wire logic req_valid,
   input wire ccrm_request_type req,
   input wire ccrm_answer_type ans,
   input wire logic ans_valid,
   // Side inputs and outputs.
   input wire logic [3:0] relay_task_in,
   input wire logic counter_cleared,
   input wire logic panel_permit_set,
   input wire ccrm_settings_type settings,
   input wire logic [7:0] station_now,
   input wire logic link_write_permit
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   a_answer_one_cycle: assert property (1'b1 |=> ans_valid == $past(req_valid))
      else $error("answer pulse does not follow its request");
   a_identity_read: assert property (req_valid && !req.write && req.address == 16'h0021
      |=> ans.data == unit_identity_code && ans.exception == 8'h00) else $error("identity read wrong");
   a_refused_blank: assert property (req_valid ##1 ans.exception != 8'h00 |-> ans.data == 16'h0000)
      else $error("refused answer carries data");
   a_permit_refuse: assert property (req_valid && req.write && !link_write_permit && !panel_permit_set
      && !$past(panel_permit_set) && $past(rst_b, 3) |=> ans.exception == 8'h08) else $error("write not refused");
   a_reply_old_station: assert property (req_valid && req.write && req.address == 16'h0020 && !$past(req_valid)
      && $past(rst_b, 3) |=> ans.reply_station == $past(station_now)) else $error("reply station not old one");
   a_station_takes_new: assert property (req_valid && req.write && req.address == 16'h0020 ##1
      ans.exception == 8'h00 |=> station_now == $past(req.data[7:0], 2)) else $error("station not updated");
   a_permit_clear: assert property (req_valid && req.write && req.address == 16'h0023 && req.data == 16'h0000
      && !panel_permit_set ##1 ans.exception == 8'h00 |=> !link_write_permit) else $error("permission not cleared");
   a_permit_sticky: assert property ($rose(link_write_permit) |-> $past(panel_permit_set, 2)
      || !$past(rst_b, 3)) else $error("permission rose without panel");
   a_level_range: assert property (req_valid && req.write && req.address == 16'h002d && link_write_permit
      && (req.data == 16'h0000 || req.data > 16'h0008) && !$past(req_valid) |=> ans.exception == 8'h03)
      else $error("level out of range accepted");
endmodule : ccrm_register_bank_checker

bind ccrm_register_bank ccrm_register_bank_checker #(.unit_identity_code(unit_identity_code))
   ccrm_register_bank_checker_inst (.clock(clock), .rst_b(rst_b), .req_valid(req_valid), .req(req), .ans(ans),
   .ans_valid(ans_valid), .relay_task_in(relay_task_in), .counter_cleared(counter_cleared),
   .panel_permit_set(panel_permit_set), .settings(settings), .station_now(station_now),
   .link_write_permit(link_write_permit));

// >>> tb/test_ccrm_register_bank.sv
/*
 Self-checking bench for the counter register bank: expected answers queue up, a monitor compares.
 Assumes the master model and the checker are compiled before this file.
*/
`timescale 1ns/10ps
module test_ccrm_register_bank
   import ccrm_pkg::*;
;
   localparam logic [15:0] id_code = 16'h3c3c; // Arbitrary value.
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic req_valid;
   ccrm_request_type req;
   ccrm_answer_type ans;
   logic ans_valid;
   logic [3:0] relay_task_in = 4'h0;
   logic counter_cleared = 1'b0;
   logic panel_permit_set = 1'b0;
   ccrm_settings_type settings;
   logic [7:0] station_now;
   logic link_write_permit;
   int n_fail = 0;
   int checks = 0;
   logic [23:0] expq[$];
   logic [5:0] addr_tab [14] = '{6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h1c, 6'h22, 6'h24, 6'h25, 6'h27,
      6'h2d, 6'h2f, 6'h32};
   logic [15:0] max_tab [14] = '{ccrm_max_policy, ccrm_max_aux, ccrm_max_clear_src, ccrm_max_auto_clear,
      ccrm_max_filter, ccrm_max_count_mode, ccrm_max_point, ccrm_max_line_rate, ccrm_max_lock,
      ccrm_max_reply_delay, ccrm_max_gap, ccrm_max_level, ccrm_max_entry, ccrm_max_relay_mode};

   ccrm_register_bank #(.unit_identity_code(id_code)) ccrm_register_bank_inst (.clock(clock), .rst_b(rst_b),
      .req_valid(req_valid), .req(req), .ans(ans), .ans_valid(ans_valid), .relay_task_in(relay_task_in),
      .counter_cleared(counter_cleared), .panel_permit_set(panel_permit_set), .settings(settings),
      .station_now(station_now), .link_write_permit(link_write_permit));
   ccrm_master_model ccrm_master_model_inst (.clock(clock), .req_valid(req_valid), .req(req));

   initial
   begin
      forever #20 clock = ~clock;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want)
      begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check

   task automatic close_out();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out

   task automatic op(input logic w, input logic [5:0] a, input logic [15:0] d, input logic [15:0] xd,
      input logic [7:0] xe);
      expq.push_back({xd, xe});
      ccrm_master_model_inst.send(w, {10'h000, a}, d);
   endtask : op

   task automatic pulse(ref logic s);
      @(posedge clock);
      #1;
      s = 1'b1;
      @(posedge clock);
      #1;
      s = 1'b0;
   endtask : pulse

   // The answer stands for one clock cycle, so the falling edge sees it settled.
   always @(negedge clock)
   begin
      if (ans_valid === 1'b1)
         check({8'h00, ans.data, ans.exception}, (expq.size() > 0) ? {8'h00, expq.pop_front()} : 32'hffff_ffff);
   end

   initial
   begin
      logic [15:0] v;
      logic [15:0] r;
      void'($urandom(32'h80d3785d));
      repeat (5) @(posedge clock);
      #1;
      rst_b = 1'b1;
      repeat (3) @(posedge clock);
      op(1'b0, 6'h17, 16'h0000, ccrm_reset_mul_low, 8'h00);
      op(1'b0, 6'h19, 16'h0000, ccrm_reset_div_low, 8'h00);
      op(1'b0, 6'h23, 16'h0000, ccrm_reset_permit, 8'h00);
      foreach (addr_tab[i])
      begin
         r = (addr_tab[i] == 6'h22) ? ccrm_reset_line_rate : (addr_tab[i] == 6'h2d) ? ccrm_reset_level : 16'h0000;
         v = (addr_tab[i] == 6'h2d) ? 16'h0001 + 16'($urandom % 8) : 16'($urandom % (32'(max_tab[i]) + 1));
         op(1'b0, addr_tab[i], 16'h0000, r, 8'h00);
         op(1'b1, addr_tab[i], v, v, 8'h00);
         op(1'b1, addr_tab[i], max_tab[i] + 16'h0001, 16'h0000, ccrm_exc_value);
         op(1'b0, addr_tab[i], 16'h0000, v, 8'h00);
      end
      op(1'b1, 6'h2d, 16'h0000, 16'h0000, ccrm_exc_value);
      // Settings follow the bank at once only under policy zero.
      op(1'b1, 6'h10, 16'h0000, 16'h0000, 8'h00);
      pulse(counter_cleared);
      op(1'b1, 6'h14, 16'h0005, 16'h0005, 8'h00);
      repeat (3) @(posedge clock);
      check(32'(settings.input_filter_rate), 32'h0000_0005);
      op(1'b1, 6'h10, 16'h0001, 16'h0001, 8'h00);
      op(1'b1, 6'h14, 16'h0007, 16'h0007, 8'h00);
      repeat (3) @(posedge clock);
      check(32'(settings.input_filter_rate), 32'h0000_0005);
      pulse(counter_cleared);
      repeat (3) @(posedge clock);
      check(32'(settings.input_filter_rate), 32'h0000_0007);
      @(posedge clock);
      #1;
      relay_task_in = 4'($urandom);
      r = {12'h000, relay_task_in};
      repeat (2) @(posedge clock);
      op(1'b0, 6'h09, 16'h0000, r, 8'h00);
      op(1'b1, 6'h09, 16'h0001, 16'h0000, ccrm_exc_address);
      op(1'b1, 6'h21, 16'h0001, 16'h0000, ccrm_exc_address);
      op(1'b0, 6'h21, 16'h0000, id_code, 8'h00);
      op(1'b0, 6'h26, 16'h0000, 16'h0000, ccrm_exc_address);
      // Split values: the high word clamps the low word, a bad low word fails.
      op(1'b1, 6'h30, 16'h0000, 16'h0000, 8'h00);
      op(1'b1, 6'h31, 16'hffff, 16'hffff, 8'h00);
      op(1'b1, 6'h30, 16'h000f, 16'h000f, 8'h00);
      op(1'b0, 6'h31, 16'h0000, 16'h423f, 8'h00);
      op(1'b1, 6'h31, 16'hffff, 16'h0000, ccrm_exc_value);
      op(1'b1, 6'h30, 16'h0010, 16'h0000, ccrm_exc_value);
      op(1'b1, 6'h16, 16'hfffe, 16'hfffe, 8'h00);
      op(1'b0, 6'h17, 16'h0000, 16'h7961, 8'h00);
      op(1'b1, 6'h19, 16'h0000, 16'h0000, ccrm_exc_value);
      op(1'b1, 6'h1a, 16'hfffd, 16'h0000, ccrm_exc_value);
      pulse(counter_cleared);
      repeat (2) @(posedge clock);
      check(settings.relay_one_threshold, 32'h000f_423f);
      check(settings.scale_factor, 32'hfffe_7961);
      op(1'b1, 6'h20, 16'h0002, 16'h0002, 8'h00);
      repeat (2) @(posedge clock);
      check(32'(station_now), 32'h0000_0002);
      op(1'b1, 6'h20, 16'h00c8, 16'h0000, ccrm_exc_value);
      op(1'b1, 6'h23, 16'h0001, 16'h0001, 8'h00);
      op(1'b1, 6'h23, 16'h0000, 16'h0000, 8'h00);
      op(1'b1, 6'h14, 16'h0001, 16'h0000, ccrm_exc_permit);
      op(1'b1, 6'h23, 16'h0001, 16'h0000, ccrm_exc_permit);
      check(32'(link_write_permit), 32'h0000_0000);
      pulse(panel_permit_set);
      repeat (3) @(posedge clock);
      op(1'b1, 6'h14, 16'h0002, 16'h0002, 8'h00);
      for (int i = 0; i < 20 && expq.size() > 0; i++)
         @(posedge clock);
      if (expq.size() > 0)
         n_fail++;
      close_out();
   end

   // A hang counts as a mismatch and still ends in the closing report.
   initial
   begin
      repeat (20000) @(posedge clock);
      n_fail++;
      close_out();
   end
endmodule : test_ccrm_register_bank
